// *** src/nco_top.v ***
// APB register file, clock selection and step buffering of the oscillator
//
// Function
// - Each selected input clock rising edge adds the active step to the accumulator.
// - Accumulator is twenty bits; carry out is the raw overflow event.
// - Overflow rate equals input rate times step over two to twenty.
// - Step is twenty bits in three readable, writable byte registers.
// - Enabled: low step byte write loads hidden buffer on second input edge.
// - Disabled: any step byte write copies into hidden buffer at once.
// - Control bit 7 enables the oscillator; zero holds it disabled.
// - Control bit 0 selects pulse mode when set, toggle mode when clear.
// - Toggle mode flips the output on every overflow, giving half rate.
// - Pulse mode: active on next input edge after overflow, then inactive.
// - Clock control bits 7-5 give pulse width of two to the value periods.
// - Pulse longer than overflow period keeps the output from toggling.
// - Control bit 4 inverts the output in the final stage.
// - Polarity change with interrupt enabled raises the overflow flag.
// - Control bit 5 reads back the current output; writes ignored.
// - Clock control bits 1-0 pick fast oscillator, system clock, logic cell.
// - Every overflow sets the sticky interrupt flag.
// - Interrupt needs module, overflow, peripheral and global enables set.
// - Reset clears every oscillator register to zero.
// - Runs in sleep; keeps fast oscillator on when enabled and selected.
//
// Local design decisions: the APB register port and the address map.
`timescale 1ns/100ps
`include "nco_defs.vh"

module nco_top (
  input  wire                    SYS_CLK,
  input  wire                    RST,
  input  wire                    CE,
  input  wire                    PSEL,
  input  wire                    PENABLE,
  input  wire                    PWRITE,
  input  wire [`NCO_ADDR_W-1:0]  PADDR,
  input  wire [`NCO_DATA_W-1:0]  PWDATA,
  input  wire [3:0]              PSTRB,
  output reg  [`NCO_DATA_W-1:0]  PRDATA,
  output wire                    PREADY,
  output reg                     PSLVERR,
  input  wire                    FAST_OSC_IN,
  input  wire                    SYS_OSC_IN,
  input  wire                    LOGIC_CELL_IN,
  output wire                    OSC_OUT,
  output wire                    ACCUM_CARRY,
  output wire                    IRQ,
  output wire                    FAST_OSC_KEEP_ON
);

  // ----------------------------------------------------------------------
  // Step buffer states
  // ----------------------------------------------------------------------
  localparam [2:0] ST_IDLE  = 3'b001;
  localparam [2:0] ST_WAIT1 = 3'b010;
  localparam [2:0] ST_WAIT2 = 3'b100;

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  function addr_hit;
    input [`NCO_ADDR_W-1:0] addr;
    input [`NCO_ADDR_W-1:0] ofs;
    begin
      addr_hit = (addr == ofs);
    end
  endfunction

  function mapped;
    input [`NCO_ADDR_W-1:0] addr;
    begin
      mapped = addr_hit(addr, `NCO_OFS_CTRL)  | addr_hit(addr, `NCO_OFS_CLK)  |
               addr_hit(addr, `NCO_OFS_ACCL)  | addr_hit(addr, `NCO_OFS_ACCH) |
               addr_hit(addr, `NCO_OFS_ACCU)  | addr_hit(addr, `NCO_OFS_INCL) |
               addr_hit(addr, `NCO_OFS_INCH)  | addr_hit(addr, `NCO_OFS_INCU) |
               addr_hit(addr, `NCO_OFS_FLAGS) | addr_hit(addr, `NCO_OFS_IRQEN);
    end
  endfunction

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  reg                      en_ff;
  reg                      pol_ff;
  reg                      pfm_ff;
  reg  [`NCO_PWS_W-1:0]    pws_ff;
  reg  [`NCO_CKS_W-1:0]    cks_ff;
  reg  [`NCO_BYTE_W-1:0]   incl_ff;
  reg  [`NCO_BYTE_W-1:0]   inch_ff;
  reg  [`NCO_UPPER_W-1:0]  incu_ff;
  reg  [`NCO_ACC_W-1:0]    incbuf_ff;
  reg  [`NCO_ACC_W-1:0]    nxt_incbuf;
  reg  [2:0]               state_ff;
  reg  [2:0]               nxt_state;
  reg                      flag_ff;
  reg                      nxt_flag;
  reg                      ie_ovf_ff;
  reg                      ie_peri_ff;
  reg                      ie_glob_ff;
  reg                      src_prev_ff;
  reg                      src_now;
  reg  [`NCO_DATA_W-1:0]   rd_mux;
  wire                     setup_ph;
  wire                     wr_acc;
  wire                     wr_en;
  wire [`NCO_BYTE_W-1:0]   wbyte;
  wire [`NCO_ACC_W-1:0]    inc_reg;
  wire [`NCO_ACC_W-1:0]    acc_value;
  wire [2:0]               acc_byte_wr;
  wire                     tick;
  wire                     carry_pulse;
  wire                     osc_out;
  wire                     wr_ctrl;
  wire                     wr_clk;
  wire                     wr_incl;
  wire                     wr_inch;
  wire                     wr_incu;
  wire                     wr_flags;
  wire                     wr_irqen;
  wire                     pol_change;
  wire [`NCO_ACC_W-1:0]    inc_after_wr;

  // ----------------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------------
  // Zero wait states; registers commit only in the access phase.
  assign PREADY   = 1'b1;
  assign setup_ph = PSEL & ~PENABLE;
  assign wr_acc   = PSEL & PENABLE & PWRITE & mapped(PADDR);
  assign wr_en    = wr_acc & PSTRB[0];
  assign wbyte    = PWDATA[`NCO_BYTE_W-1:0];

  assign wr_ctrl  = wr_en & addr_hit(PADDR, `NCO_OFS_CTRL);
  assign wr_clk   = wr_en & addr_hit(PADDR, `NCO_OFS_CLK);
  assign wr_incl  = wr_en & addr_hit(PADDR, `NCO_OFS_INCL);
  assign wr_inch  = wr_en & addr_hit(PADDR, `NCO_OFS_INCH);
  assign wr_incu  = wr_en & addr_hit(PADDR, `NCO_OFS_INCU);
  assign wr_flags = wr_en & addr_hit(PADDR, `NCO_OFS_FLAGS);
  assign wr_irqen = wr_en & addr_hit(PADDR, `NCO_OFS_IRQEN);

  // Accumulator bytes are written straight through; no atomicity while running.
  assign acc_byte_wr = {wr_en & addr_hit(PADDR, `NCO_OFS_ACCU),
                        wr_en & addr_hit(PADDR, `NCO_OFS_ACCH),
                        wr_en & addr_hit(PADDR, `NCO_OFS_ACCL)};

  assign inc_reg = {incu_ff, inch_ff, incl_ff};

  // ----------------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------------
  always @* begin
    rd_mux = {`NCO_DATA_W{1'b0}};
    if (addr_hit(PADDR, `NCO_OFS_CTRL)) begin
      rd_mux[`NCO_CTRL_EN]  = en_ff;
      rd_mux[`NCO_CTRL_OUT] = osc_out;
      rd_mux[`NCO_CTRL_POL] = pol_ff;
      rd_mux[`NCO_CTRL_PFM] = pfm_ff;
    end else if (addr_hit(PADDR, `NCO_OFS_CLK)) begin
      rd_mux[`ACCUMULATOR_CLOCK_PWS_HI:`ACCUMULATOR_CLOCK_PWS_LO] = pws_ff;
      rd_mux[`ACCUMULATOR_CLOCK_CKS_HI:`ACCUMULATOR_CLOCK_CKS_LO] = cks_ff;
    end else if (addr_hit(PADDR, `NCO_OFS_ACCL)) begin
      rd_mux[7:0] = acc_value[7:0];
    end else if (addr_hit(PADDR, `NCO_OFS_ACCH)) begin
      rd_mux[7:0] = acc_value[15:8];
    end else if (addr_hit(PADDR, `NCO_OFS_ACCU)) begin
      rd_mux[`NCO_UPPER_W-1:0] = acc_value[19:16];
    end else if (addr_hit(PADDR, `NCO_OFS_INCL)) begin
      rd_mux[7:0] = incl_ff;
    end else if (addr_hit(PADDR, `NCO_OFS_INCH)) begin
      rd_mux[7:0] = inch_ff;
    end else if (addr_hit(PADDR, `NCO_OFS_INCU)) begin
      rd_mux[`NCO_UPPER_W-1:0] = incu_ff;
    end else if (addr_hit(PADDR, `NCO_OFS_FLAGS)) begin
      rd_mux[`NCO_FLAG_OVF] = flag_ff;
    end else if (addr_hit(PADDR, `NCO_OFS_IRQEN)) begin
      rd_mux[`NCO_IEN_OVF]  = ie_ovf_ff;
      rd_mux[`NCO_IEN_PERI] = ie_peri_ff;
      rd_mux[`NCO_IEN_GLOB] = ie_glob_ff;
    end
  end

  // Read data and error are captured in the setup phase, stable in access.
  always @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      PRDATA  <= {`NCO_DATA_W{1'b0}};
      PSLVERR <= 1'b0;
    end else if (CE) begin
      if (setup_ph) begin
        PRDATA  <= PWRITE ? {`NCO_DATA_W{1'b0}} : rd_mux;
        PSLVERR <= ~mapped(PADDR);
      end
    end
  end

  // ----------------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------------
  always @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      en_ff      <= 1'b0;
      pol_ff     <= 1'b0;
      pfm_ff     <= 1'b0;
      pws_ff     <= {`NCO_PWS_W{1'b0}};
      cks_ff     <= {`NCO_CKS_W{1'b0}};
      incl_ff    <= `NCO_RST_BYTE;
      inch_ff    <= `NCO_RST_BYTE;
      incu_ff    <= {`NCO_UPPER_W{1'b0}};
      ie_ovf_ff  <= 1'b0;
      ie_peri_ff <= 1'b0;
      ie_glob_ff <= 1'b0;
    end else if (CE) begin
      if (wr_ctrl) begin
        en_ff  <= wbyte[`NCO_CTRL_EN];
        pol_ff <= wbyte[`NCO_CTRL_POL];
        pfm_ff <= wbyte[`NCO_CTRL_PFM];
      end
      if (wr_clk) begin
        pws_ff <= wbyte[`ACCUMULATOR_CLOCK_PWS_HI:`ACCUMULATOR_CLOCK_PWS_LO];
        cks_ff <= wbyte[`ACCUMULATOR_CLOCK_CKS_HI:`ACCUMULATOR_CLOCK_CKS_LO];
      end
      if (wr_incl) begin
        incl_ff <= wbyte;
      end
      if (wr_inch) begin
        inch_ff <= wbyte;
      end
      if (wr_incu) begin
        incu_ff <= wbyte[`NCO_UPPER_W-1:0];
      end
      if (wr_irqen) begin
        ie_ovf_ff  <= wbyte[`NCO_IEN_OVF];
        ie_peri_ff <= wbyte[`NCO_IEN_PERI];
        ie_glob_ff <= wbyte[`NCO_IEN_GLOB];
      end
    end
  end

  // ----------------------------------------------------------------------
  // Clock source selection
  // ----------------------------------------------------------------------
  // Sources are synchronous to SYS_CLK, so a plain edge detect is enough;
  // the selected source must stay below half the SYS_CLK rate.
  always @* begin
    case (cks_ff)
      `NCO_CKS_FAST:   src_now = FAST_OSC_IN;
      `NCO_CKS_SYSOSC: src_now = SYS_OSC_IN;
      `NCO_CKS_LCELL:  src_now = LOGIC_CELL_IN;
      default:         src_now = 1'b0;
    endcase
  end

  always @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      src_prev_ff <= 1'b0;
    end else if (CE) begin
      src_prev_ff <= src_now;
    end
  end

  assign tick             = src_now & ~src_prev_ff;
  assign FAST_OSC_KEEP_ON = en_ff & (cks_ff == `NCO_CKS_FAST);

  // ----------------------------------------------------------------------
  // Hidden step buffer
  // ----------------------------------------------------------------------
  // While disabled, the buffer takes the register image including the byte being written now.
  assign inc_after_wr = {wr_incu ? wbyte[`NCO_UPPER_W-1:0] : incu_ff,
                         wr_inch ? wbyte : inch_ff,
                         wr_incl ? wbyte : incl_ff};

  always @* begin
    nxt_state  = state_ff;
    nxt_incbuf = incbuf_ff;
    if (!en_ff) begin
      nxt_state = ST_IDLE;
      if (wr_incl | wr_inch | wr_incu) begin
        nxt_incbuf = inc_after_wr;
      end else if (state_ff != ST_IDLE) begin
        nxt_incbuf = inc_reg;
      end
    end else begin
      case (state_ff)
        ST_IDLE: begin
          if (wr_incl) begin
            nxt_state = tick ? ST_WAIT2 : ST_WAIT1;
          end
        end
        ST_WAIT1: begin
          if (tick) begin
            nxt_state = ST_WAIT2;
          end
        end
        ST_WAIT2: begin
          if (tick) begin
            nxt_incbuf = inc_reg;
            nxt_state  = wr_incl ? ST_WAIT1 : ST_IDLE;
          end else if (wr_incl) begin
            nxt_state = ST_WAIT1;
          end
        end
        default: begin
          nxt_state = ST_IDLE;
        end
      endcase
    end
  end

  always @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      state_ff  <= ST_IDLE;
      incbuf_ff <= `NCO_RST_ACC;
    end else if (CE) begin
      state_ff  <= nxt_state;
      incbuf_ff <= nxt_incbuf;
    end
  end

  // ----------------------------------------------------------------------
  // Oscillator core
  // ----------------------------------------------------------------------
  nco_core u_core (
    .clk                (SYS_CLK),
    .rst                (RST),
    .ce                 (CE),
    .tick               (tick),
    .enable             (en_ff),
    .pulse_mode         (pfm_ff),
    .polarity           (pol_ff),
    .pulse_width_select (pws_ff),
    .step_value         (incbuf_ff),
    .acc_byte_wr        (acc_byte_wr),
    .acc_wdata          (wbyte),
    .acc_value          (acc_value),
    .carry_pulse        (carry_pulse),
    .osc_out            (osc_out)
  );

  assign OSC_OUT     = osc_out;
  assign ACCUM_CARRY = carry_pulse;

  // ----------------------------------------------------------------------
  // Interrupt flag
  // ----------------------------------------------------------------------
  assign pol_change = wr_ctrl & (wbyte[`NCO_CTRL_POL] != pol_ff) & ie_ovf_ff;

  // Set beats a same-cycle software clear so no overflow is lost.
  always @* begin
    nxt_flag = flag_ff;
    if (wr_flags & ~wbyte[`NCO_FLAG_OVF]) begin
      nxt_flag = 1'b0;
    end
    if (carry_pulse | pol_change) begin
      nxt_flag = 1'b1;
    end
  end

  always @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      flag_ff <= 1'b0;
    end else if (CE) begin
      flag_ff <= nxt_flag;
    end
  end

  assign IRQ = flag_ff & en_ff & ie_ovf_ff & ie_peri_ff & ie_glob_ff;

endmodule // nco_top

// *** src/nco_defs.vh ***
// Constants shared by the phase accumulator oscillator design files
`ifndef NCO_DEFS_VH
`define NCO_DEFS_VH

// ----------------------------------------------------------------------
// Widths
// ----------------------------------------------------------------------
`define NCO_ACC_W        20
`define NCO_BYTE_W       8
`define NCO_UPPER_W      4
`define NCO_ADDR_W       8
`define NCO_DATA_W       32
`define NCO_PWS_W        3
`define NCO_CKS_W        2
`define NCO_PCNT_W       8

// ----------------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------------
`define NCO_OFS_CTRL     8'h00
`define NCO_OFS_CLK      8'h04
`define NCO_OFS_ACCL     8'h08
`define NCO_OFS_ACCH     8'h0C
`define NCO_OFS_ACCU     8'h10
`define NCO_OFS_INCL     8'h14
`define NCO_OFS_INCH     8'h18
`define NCO_OFS_INCU     8'h1C
`define NCO_OFS_FLAGS    8'h20
`define NCO_OFS_IRQEN    8'h24

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define NCO_CTRL_EN      7
`define NCO_CTRL_OUT     5
`define NCO_CTRL_POL     4
`define NCO_CTRL_PFM     0
`define ACCUMULATOR_CLOCK_PWS_HI   7
`define ACCUMULATOR_CLOCK_PWS_LO   5
`define ACCUMULATOR_CLOCK_CKS_HI   1
`define ACCUMULATOR_CLOCK_CKS_LO   0
`define NCO_FLAG_OVF     0
`define NCO_IEN_OVF      0
`define NCO_IEN_PERI     1
`define NCO_IEN_GLOB     2

// ----------------------------------------------------------------------
// Clock source codes
// ----------------------------------------------------------------------
`define NCO_CKS_FAST     2'h0
`define NCO_CKS_SYSOSC   2'h1
`define NCO_CKS_LCELL    2'h2

// ----------------------------------------------------------------------
// Reset values and the pulse counter unit step
// ----------------------------------------------------------------------
`define NCO_RST_BYTE     8'h00
`define NCO_RST_ACC      20'h00000
`define NCO_RST_PCNT     8'h00
`define NCO_PCNT_ONE     8'h01

`endif

// *** src/nco_core.v ***
// Accumulator, adder and output stage of the phase accumulator oscillator
`timescale 1ns/100ps
`include "nco_defs.vh"

module nco_core (
  input  wire                    clk,
  input  wire                    rst,
  input  wire                    ce,
  input  wire                    tick,
  input  wire                    enable,
  input  wire                    pulse_mode,
  input  wire                    polarity,
  input  wire [`NCO_PWS_W-1:0]   pulse_width_select,
  input  wire [`NCO_ACC_W-1:0]   step_value,
  input  wire [2:0]              acc_byte_wr,
  input  wire [`NCO_BYTE_W-1:0]  acc_wdata,
  output wire [`NCO_ACC_W-1:0]   acc_value,
  output wire                    carry_pulse,
  output wire                    osc_out
);

  reg  [`NCO_ACC_W-1:0]  acc_ff;
  reg  [`NCO_ACC_W-1:0]  nxt_acc;
  reg                    ovf_ff;
  reg                    raw_ff;
  reg                    nxt_raw;
  reg  [`NCO_PCNT_W-1:0] pcnt_ff;
  reg  [`NCO_PCNT_W-1:0] nxt_pcnt;
  wire [`NCO_ACC_W:0]    sum;
  wire                   step_now;

  // ----------------------------------------------------------------------
  // Adder
  // ----------------------------------------------------------------------
  assign step_now    = tick & enable;
  assign sum         = {1'b0, acc_ff} + {1'b0, step_value};
  assign carry_pulse = step_now & sum[`NCO_ACC_W];

  always @* begin
    nxt_acc = acc_ff;
    if (step_now) begin
      nxt_acc = sum[`NCO_ACC_W-1:0];
    end
    if (acc_byte_wr[0]) begin
      nxt_acc[7:0] = acc_wdata;
    end
    if (acc_byte_wr[1]) begin
      nxt_acc[15:8] = acc_wdata;
    end
    if (acc_byte_wr[2]) begin
      nxt_acc[19:16] = acc_wdata[`NCO_UPPER_W-1:0];
    end
  end

  // ----------------------------------------------------------------------
  // Output stage
  // ----------------------------------------------------------------------
  // Pulse start waits one input edge after the overflow; a new overflow
  // while still active reloads the width so the output never drops.
  always @* begin
    nxt_raw  = raw_ff;
    nxt_pcnt = pcnt_ff;
    if (step_now) begin
      if (!pulse_mode) begin
        nxt_pcnt = `NCO_RST_PCNT;
        if (carry_pulse) begin
          nxt_raw = ~raw_ff;
        end
      end else if (ovf_ff) begin
        nxt_raw  = 1'b1;
        nxt_pcnt = (`NCO_PCNT_ONE << pulse_width_select) - `NCO_PCNT_ONE;
      end else if (raw_ff) begin
        if (pcnt_ff == `NCO_RST_PCNT) begin
          nxt_raw = 1'b0;
        end else begin
          nxt_pcnt = pcnt_ff - `NCO_PCNT_ONE;
        end
      end
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      acc_ff  <= `NCO_RST_ACC;
      ovf_ff  <= 1'b0;
      raw_ff  <= 1'b0;
      pcnt_ff <= `NCO_RST_PCNT;
    end else if (ce) begin
      acc_ff  <= nxt_acc;
      raw_ff  <= nxt_raw;
      pcnt_ff <= nxt_pcnt;
      if (step_now) begin
        ovf_ff <= carry_pulse;
      end
    end
  end

  assign acc_value = acc_ff;
  assign osc_out   = raw_ff ^ polarity;

endmodule // nco_core

// *** tb/nco_chk.sv ***
// Port checker of the phase accumulator oscillator
`timescale 1ns/100ps
module nco_chk (
  input wire        SYS_CLK,
  input wire        RST,
  input wire        PSEL,
  input wire        PENABLE,
  input wire        PWRITE,
  input wire [7:0]  PADDR,
  input wire [31:0] PRDATA,
  input wire        PREADY,
  input wire        PSLVERR,
  input wire        FAST_OSC_IN,
  input wire        SYS_OSC_IN,
  input wire        LOGIC_CELL_IN,
  input wire        OSC_OUT,
  input wire        ACCUM_CARRY,
  input wire        IRQ,
  input wire        FAST_OSC_KEEP_ON
);
  // ----
  // Source edges and bus writes
  // ----
  wire [2:0] src = {LOGIC_CELL_IN, SYS_OSC_IN, FAST_OSC_IN};
  reg  [2:0] src_ff;
  wire [2:0] tk  = src & ~src_ff;
  wire       wr  = PSEL && PENABLE && PWRITE;
  always @(posedge SYS_CLK) begin
    src_ff <= src;
  end
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (RST);
  ready_high_a: assert property (PREADY)
    else $error("ready low");
  slverr_map_a: assert property (PSEL && !PENABLE && PADDR > 8'h24 |=> PSLVERR && PRDATA == 0)
    else $error("unmapped access not refused");
  slverr_ok_a: assert property (PSEL && !PENABLE && PADDR[1:0] == 0 && PADDR <= 8'h24 |=> !PSLVERR)
    else $error("mapped access refused");
  rdata_hold_a: assert property (!PSEL |=> $stable(PRDATA))
    else $error("read data moved while idle");
  carry_tick_a: assert property (ACCUM_CARRY |-> (|tk) || $past(|tk))
    else $error("carry without source edge");
  carry_gap_a: assert property (ACCUM_CARRY |=> !ACCUM_CARRY)
    else $error("carry longer than one cycle");
  out_cause_a: assert property ($changed(OSC_OUT) |-> $past(ACCUM_CARRY || (|tk) || wr))
    else $error("output moved without cause");
  irq_clear_a: assert property ($fell(IRQ) |-> $past(wr))
    else $error("interrupt dropped by hardware");
  keep_on_a: assert property ($changed(FAST_OSC_KEEP_ON) |-> $past(wr))
    else $error("keep-alive moved without write");
  cover property (ACCUM_CARRY);
  cover property (PSLVERR);
  cover property ($fell(IRQ));
endmodule // nco_chk
bind nco_top nco_chk nco_chk_inst (.*);

// *** tb/nco_top_test.sv ***
// Self-checking bench of the phase accumulator oscillator
`timescale 1ns/100ps
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin failures++; \
  $display("ERROR %0t got %h exp %h", $time, a, e); end end
module nco_top_test;
  logic        clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, tog = 0, ce = 1;
  logic [7:0]  pa = 0, w;
  logic [31:0] pwd = 0, prd, ex;
  logic [2:0]  src = 0;
  logic [19:0] s;
  logic [39:0] e;
  logic        rdy, err, out, car, irq, keep;
  logic [31:0] exq[$];
  logic [7:0]  msk[10] = '{8'h01, 8'hE3, 8'hFF, 8'hFF, 8'h0F, 8'hFF, 8'hFF, 8'h0F, 8'h00, 8'h07};
  int          failures = 0, cmp_count = 0, cyc = 0;
  // Four-state counters so an unknown carry or output cannot pass as zero
  integer      seed = 32'hAFC9DFA6, ncar = 0, nhi = 0;
  nco_top nco_top_inst (.SYS_CLK(clk), .RST(rst), .CE(ce), .PSEL(psel), .PENABLE(pen),
    .PWRITE(pwr), .PADDR(pa), .PWDATA(pwd), .PSTRB(4'hF), .PRDATA(prd), .PREADY(rdy),
    .PSLVERR(err), .FAST_OSC_IN(src[0]), .SYS_OSC_IN(src[1]), .LOGIC_CELL_IN(src[2]),
    .OSC_OUT(out), .ACCUM_CARRY(car), .IRQ(irq), .FAST_OSC_KEEP_ON(keep));
  initial forever #25 clk = ~clk;
  // ----
  // Bus and source drivers
  // ----
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    if (!w)
      exq.push_back(d);
    psel <= 1;
    pen <= 0;
    pwr <= w;
    pa <= a;
    pwd <= w ? d : 0;
    @(posedge clk);
    pen <= 1;
    do @(posedge clk); while (!rdy);
    psel <= 0;
    pen <= 0;
  endtask
  // Sources must stay below half the bus clock, so two cycles high, two low
  task automatic tick(input int n, input logic [2:0] m);
    repeat (n) begin
      @(posedge clk);
      src <= m;
      repeat (2) @(posedge clk);
      src <= 0;
      @(posedge clk);
    end
  endtask
  task automatic step(input logic [19:0] v);
    bus(1, 8'h1C, v[19:16]);
    bus(1, 8'h18, v[15:8]);
    bus(1, 8'h14, v[7:0]);
  endtask
  task automatic racc(input logic [19:0] v);
    bus(0, 8'h08, v[7:0]);
    bus(0, 8'h0C, v[15:8]);
    bus(0, 8'h10, v[19:16]);
  endtask
  task automatic final_report;
    $display("Mismatches %0d, comparisons %0d", failures, cmp_count);
    if (failures == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    ncar += car;
    nhi += out;
    if (psel && pen && rdy && !pwr) begin
      ex = exq.pop_front();
      `CHK(prd, ex)
    end
    if (cyc == 5000) begin
      failures++;
      final_report;
    end
  end
  initial begin
    repeat (16) @(posedge clk);
    rst <= 0;
    for (int i = 0; i < 11; i++)
      bus(0, 8'(4 * i), 0);
    for (int i = 0; i < 10; i++) begin
      w = $random(seed);
      if (i == 0)
        w = w & 8'h6F;
      bus(1, 8'(4 * i), w);
      bus(0, 8'(4 * i), w & msk[i]);
    end
    bus(1, 8'h24, 8'h07);
    for (int c = 0; c < 4; c++) begin
      s = $random(seed);
      bus(1, 8'h00, 0);
      for (int j = 2; j < 5; j++)
        bus(1, 8'(4 * j), 0);
      step(s);
      bus(1, 8'h04, c);
      bus(1, 8'h20, 0);
      ncar = 0;
      bus(1, 8'h00, 8'h80);
      #1 `CHK(keep, c == 0)
      tick(9, c == 3 ? 3'h7 : 3'h1 << c);
      e = (c == 3) ? 0 : 9 * s;
      tog ^= e[20];
      #1 `CHK(out, tog)
      `CHK(irq, e[39:20] != 0)
      `CHK(ncar, e[39:20])
      bus(1, 8'h00, 0);
      #1 `CHK(irq, 1'b0)
      racc(e[19:0]);
    end
    bus(1, 8'h04, 8'h01);
    step(20'h00010);
    bus(1, 8'h00, 8'h80);
    step(20'h00300);
    tick(5, 3'h2);
    // Ticks while the clock enable is low must not reach the accumulator
    ce <= 0;
    tick(2, 3'h2);
    ce <= 1;
    bus(1, 8'h00, 0);
    racc(20'h00920);
    rst <= 1;
    repeat (2) @(posedge clk);
    rst <= 0;
    bus(1, 8'h04, 8'h21);
    step(20'h40000);
    bus(1, 8'h00, 8'h81);
    nhi = 0;
    tick(16, 3'h2);
    `CHK(nhi, 24)
    bus(1, 8'h24, 8'h01);
    bus(1, 8'h20, 0);
    bus(1, 8'h00, 8'h91);
    #1 `CHK(out, 1'b1)
    bus(0, 8'h20, 1);
    repeat (2) @(posedge clk);
    `CHK(exq.size(), 0)
    final_report;
  end
endmodule // nco_top_test
